// ### core/dma_bus_cycle_config.sv
`timescale 1ns/1ps

// How it works
// - A configuration bit picks synchronous or asynchronous handling of ready in DMA.
// - Ready comes from ready_in when strap is 0, size_ack_pair when strap is 1.
// - Asynchronous mode passes ready through a falling-edge synchroniser during T2.
// - Asynchronous mode: every DMA memory cycle lasts at least three bus clocks.
// - Synchronous mode samples ready through two rising-edge flops, checked only in T2.
// - Two user bits read back the strap pin levels seen during hardware reset.
// - Strap levels are captured as hardware reset is released.
// - Captured strap bits hold until the next hardware reset.
// - Two-bit wait field sets how many first T2 states ignore ready; code 01 ignores it in one.
module dma_bus_cycle_config (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// DMA engine side
	input  wire logic        dma_req,
	output logic             cycle_t1,
	output logic             cycle_t2,
	output logic             cycle_done,
	// Pins
	input  wire logic        ready_in,
	input  wire logic [1:0]  size_ack_pair,
	input  wire logic        bus_style_strap,
	input  wire logic [1:0]  user_strap_pins
);

	// Pin synchronisers, rising edge
	logic [1:0]  ack_s1_q, ack_s1_d, ack_s2_q, ack_s2_d;
	logic        rdy_s1_q, rdy_s1_d, rdy_s2_q, rdy_s2_d;
	logic [2:0]  strap_s1_q, strap_s1_d, strap_s2_q, strap_s2_d;

	always_comb begin
		rdy_s1_d   = ready_in;
		rdy_s2_d   = rdy_s1_q;
		ack_s1_d   = size_ack_pair;
		ack_s2_d   = ack_s1_q;
		strap_s1_d = {bus_style_strap, user_strap_pins};
		strap_s2_d = strap_s1_q;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdy_s1_q   <= 1'b0;
			rdy_s2_q   <= 1'b0;
			ack_s1_q   <= 2'h0;
			ack_s2_q   <= 2'h0;
		end else begin
			rdy_s1_q   <= rdy_s1_d;
			rdy_s2_q   <= rdy_s2_d;
			ack_s1_q   <= ack_s1_d;
			ack_s2_q   <= ack_s2_d;
		end
	end

	// Strap stages keep running in reset, so the pin level is
	// already through both of them when capture happens at release
	always_ff @(posedge clk_sys) begin
		strap_s1_q <= strap_s1_d;
		strap_s2_q <= strap_s2_d;
	end

	// Falling-edge synchroniser for the asynchronous ready path
	logic [1:0]  ack_f1_q, ack_f1_d, ack_f2_q, ack_f2_d;
	logic        rdy_f1_q, rdy_f1_d, rdy_f2_q, rdy_f2_d;

	always_comb begin
		rdy_f1_d = ready_in;
		ack_f1_d = size_ack_pair;
		rdy_f2_d = rdy_f1_q;
		ack_f2_d = ack_f1_q;
	end

	// First stage on the falling edge buys half a clock of settling
	always_ff @(negedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdy_f1_q <= 1'b0;
			ack_f1_q <= 2'h0;
		end else begin
			rdy_f1_q <= rdy_f1_d;
			ack_f1_q <= ack_f1_d;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdy_f2_q <= 1'b0;
			ack_f2_q <= 2'h0;
		end else begin
			rdy_f2_q <= rdy_f2_d;
			ack_f2_q <= ack_f2_d;
		end
	end

	// Strap capture on the first clock after release, so that
	// no register is clocked by the reset pin itself
	logic        captured_q, captured_d;
	logic [1:0]  user_q, user_d;
	logic        style_q, style_d;

	always_comb begin
		captured_d = 1'b1;
		user_d     = user_q;
		style_d    = style_q;
		if (!captured_q) begin
			user_d  = strap_s2_q[1:0];
			style_d = strap_s2_q[2];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			captured_q <= 1'b0;
			user_q     <= 2'h0;
			style_q    <= 1'b0;
		end else begin
			captured_q <= captured_d;
			user_q     <= user_d;
			style_q    <= style_d;
		end
	end

	// Sequencer state, read by the status view
	dma_cycle_pkg::cyc_state_e state_q, state_d;
	logic [7:0]  clk_cnt_q, clk_cnt_d;
	logic [1:0]  waits_q, waits_d;
	logic        rdy_eff;
	logic        done_d, done_q, t1_d, t1_q, t2_d, t2_q;
	logic [7:0]  min_clks;

	// Configuration register and bus slave
	logic [15:0] cfg_q, cfg_d;
	logic        wr_pend_q, wr_pend_d;
	logic [7:0]  wr_addr_q, wr_addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic [15:0] cfg_view, status_view;
	logic [7:0]  len_q, len_d;
	logic        acc;
	logic        sync_mode;

	assign sync_mode = cfg_q[dma_cycle_pkg::CFG_SYNC_BIT];
	assign acc = hsel && hready &&
		(htrans == dma_cycle_pkg::HTRANS_NONSEQ || htrans == dma_cycle_pkg::HTRANS_SEQ);

	always_comb begin
		wr_pend_d = acc && hwrite;
		wr_addr_d = haddr[7:0] & dma_cycle_pkg::ADDR_MASK;
		cfg_d     = cfg_q;
		if (wr_pend_q && wr_addr_q == dma_cycle_pkg::CFG_OFFSET)
			cfg_d = hwdata[15:0] & dma_cycle_pkg::CFG_WR_MASK;
		cfg_d[dma_cycle_pkg::CFG_STRAP_HI:dma_cycle_pkg::CFG_STRAP_LO] = user_d;
	end

	// Status is a live view of sequencer and strap state
	always_comb begin
		status_view = 16'h0000;
		status_view[dma_cycle_pkg::STAT_BUSY_BIT]  = (state_q != dma_cycle_pkg::CYC_IDLE);
		status_view[dma_cycle_pkg::STAT_SYNC_BIT]  = sync_mode;
		status_view[dma_cycle_pkg::STAT_STYLE_BIT] = style_q;
		status_view[dma_cycle_pkg::STAT_LEN_HI:dma_cycle_pkg::STAT_LEN_LO] = len_q;
	end

	// Reads see this cycle's write, so read after write needs no gap
	always_comb begin
		cfg_view = cfg_d;
		rdata_d  = 32'h0000_0000;
		if (acc && !hwrite) begin
			if (haddr[7:0] == dma_cycle_pkg::CFG_OFFSET)
				rdata_d = {16'h0000, cfg_view};
			else if (haddr[7:0] == dma_cycle_pkg::STATUS_OFFSET)
				rdata_d = {16'h0000, status_view};
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg_q     <= dma_cycle_pkg::CFG_RESET;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q   <= 32'h0000_0000;
		end else begin
			cfg_q     <= cfg_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q   <= rdata_d;
		end
	end

	// DMA cycle sequencer
	// Both ready paths pass two flops; a pin change reaches the decision about
	// two clocks late in synchronous mode, one clock in asynchronous mode (falling
	// first stage): the pin rule outweighs latency
	always_comb begin
		if (sync_mode)
			rdy_eff = style_q ? (|ack_s2_q) : rdy_s2_q;
		else
			rdy_eff = style_q ? (|ack_f2_q) : rdy_f2_q;
		min_clks = sync_mode ? dma_cycle_pkg::MIN_CLKS_SYNC
			: dma_cycle_pkg::MIN_CLKS_ASYNC;
	end

	always_comb begin
		state_d   = state_q;
		clk_cnt_d = clk_cnt_q;
		waits_d   = waits_q;
		len_d     = len_q;
		done_d    = 1'b0;
		if (clk_cnt_q != dma_cycle_pkg::LEN_MAX)
			clk_cnt_d = clk_cnt_q + 8'h01;
		unique case (state_q)
			dma_cycle_pkg::CYC_IDLE: begin
				clk_cnt_d = 8'h01;
				if (dma_req)
					state_d = dma_cycle_pkg::CYC_T1;
				else
					clk_cnt_d = 8'h00;
			end
			dma_cycle_pkg::CYC_T1: begin
				state_d = dma_cycle_pkg::CYC_T2;
				// Code value equals the count of first T2 states that ignore ready
				waits_d = cfg_q[dma_cycle_pkg::CFG_WAIT_HI:dma_cycle_pkg::CFG_WAIT_LO];
			end
			dma_cycle_pkg::CYC_T2: begin
				if (waits_q != 2'h0)
					waits_d = waits_q - 2'h1;
				else if (rdy_eff && clk_cnt_q >= min_clks) begin
					state_d   = dma_cycle_pkg::CYC_IDLE;
					done_d    = 1'b1;
					len_d     = clk_cnt_q;
					clk_cnt_d = 8'h00;
				end
			end
			// Unused state code falls back to idle
			default: begin
				state_d   = dma_cycle_pkg::CYC_IDLE;
				clk_cnt_d = 8'h00;
			end
		endcase
		t1_d = (state_d == dma_cycle_pkg::CYC_T1);
		t2_d = (state_d == dma_cycle_pkg::CYC_T2);
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q   <= dma_cycle_pkg::CYC_IDLE;
			clk_cnt_q <= 8'h00;
			waits_q   <= 2'h0;
			len_q     <= 8'h00;
			done_q    <= 1'b0;
			t1_q      <= 1'b0;
			t2_q      <= 1'b0;
		end else begin
			state_q   <= state_d;
			clk_cnt_q <= clk_cnt_d;
			waits_q   <= waits_d;
			len_q     <= len_d;
			done_q    <= done_d;
			t1_q      <= t1_d;
			t2_q      <= t2_d;
		end
	end

	// Zero-wait slave, always OKAY
	logic        rdyo_q, rdyo_d, resp_q, resp_d;

	// Constant answers still leave from flops, like every bus output
	always_comb begin
		rdyo_d = 1'b1;
		resp_d = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdyo_q <= 1'b1;
			resp_q <= 1'b0;
		end else begin
			rdyo_q <= rdyo_d;
			resp_q <= resp_d;
		end
	end

	assign hreadyout  = rdyo_q;
	assign hresp      = resp_q;
	assign hrdata     = rdata_q;
	assign cycle_t1   = t1_q;
	assign cycle_t2   = t2_q;
	assign cycle_done = done_q;

endmodule : dma_bus_cycle_config

// ### core/dma_cycle_pkg.sv
package dma_cycle_pkg;
	// Register byte offsets
	localparam logic [7:0]  CFG_OFFSET    = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET = 8'h04;
	localparam logic [7:0]  ADDR_MASK     = 8'hff;

	// Configuration field layout
	localparam int          CFG_EXT_BUS_BIT   = 15;
	localparam int          CFG_ZERO_BIT      = 14;
	localparam int          CFG_LATCH_RTY_BIT = 13;
	localparam int          CFG_SYNC_BIT      = 10;
	localparam int          CFG_STRAP_HI      = 9;
	localparam int          CFG_STRAP_LO      = 8;
	localparam int          CFG_WAIT_HI       = 7;
	localparam int          CFG_WAIT_LO       = 6;
	localparam logic [15:0] CFG_RESET         = 16'h0000;
	localparam logic [15:0] CFG_WR_MASK       = 16'hbcff;

	// Status field layout
	localparam int          STAT_BUSY_BIT = 0;
	localparam int          STAT_SYNC_BIT = 1;
	localparam int          STAT_STYLE_BIT = 2;
	localparam int          STAT_LEN_LO   = 8;
	localparam int          STAT_LEN_HI   = 15;

	// Cycle timing
	localparam logic [7:0]  MIN_CLKS_ASYNC = 8'h03;
	localparam logic [7:0]  MIN_CLKS_SYNC  = 8'h02;
	localparam logic [7:0]  LEN_MAX        = 8'hff;

	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_T1,
		CYC_T2
	} cyc_state_e;
endpackage : dma_cycle_pkg

// ### testbench/dma_cycle_checker.sv
`timescale 1ns/1ps
module dma_cycle_checker (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       nrst,
	// Watched ports
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       cycle_t1,
	input wire logic       cycle_t2,
	input wire logic       cycle_done,
	input wire logic       ready_in,
	input wire logic [1:0] size_ack_pair
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Both ready sources quiet, so neither strap choice can end T2
	sequence s_no_ack;
		(cycle_t2 && !ready_in && size_ack_pair == 2'h0)[*4];
	endsequence
	sequence s_all_ack;
		(cycle_t2 && ready_in && size_ack_pair == 2'h3)[*4];
	endsequence
	property p_t2_after_t1; cycle_t1 |=> cycle_t2; endproperty
	a_t2_after_t1: assert property (p_t2_after_t1) else $error("no T2 after T1");
	property p_t1_single; cycle_t1 |=> !cycle_t1; endproperty
	a_t1_single: assert property (p_t1_single) else $error("T1 too long");
	property p_t1_alone; cycle_t1 |-> !cycle_t2 && !cycle_done; endproperty
	a_t1_alone: assert property (p_t1_alone) else $error("T1 overlaps");
	property p_done_end; cycle_t2 ##1 !cycle_t2 |-> cycle_done; endproperty
	a_done_end: assert property (p_done_end) else $error("no done after T2");
	property p_hold; s_no_ack |=> cycle_t2; endproperty
	a_hold: assert property (p_hold) else $error("T2 ended without ready");
	property p_end; s_all_ack |-> ##[0:4] !cycle_t2; endproperty
	a_end: assert property (p_end) else $error("ready ignored");
	property p_okay; !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_no_wait; hreadyout; endproperty
	a_no_wait: assert property (p_no_wait) else $error("bus stalled");
endmodule : dma_cycle_checker

// ### testbench/ready_responder.sv
`timescale 1ns/1ps
module ready_responder (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// Cycle view and control
	input wire logic        cycle_t1,
	input wire logic        cycle_t2,
	input wire logic        style,
	input wire logic        decoy,
	input wire logic [3:0]  delay,
	// Ready lines
	output logic            ready_in,
	output logic [1:0]      size_ack_pair
);
	logic [3:0] cnt_q;
	logic       ack_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
		end else begin
			cnt_q <= (cycle_t1 || cycle_t2) ? cnt_q + 4'h1 : 4'h0;
			ack_q <= (cycle_t1 || cycle_t2) && cnt_q >= delay;
		end
	end
	// Unused line carries a decoy so a wrong select shows up
	assign ready_in      = style ? decoy : ack_q;
	assign size_ack_pair = style ? {2{ack_q}} : {2{decoy}};
endmodule : ready_responder

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk_sys, nrst, hsel, hwrite, dma_req, strap, decoy;
	logic        hreadyout, hresp, t1, t2, done, rdy;
	logic [1:0]  htrans, pins, ack;
	logic [3:0]  delay;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          miscompares, checks_done;
	dma_bus_cycle_config DUT (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dma_req(dma_req),
		.cycle_t1(t1), .cycle_t2(t2), .cycle_done(done), .ready_in(rdy),
		.size_ack_pair(ack), .bus_style_strap(strap), .user_strap_pins(pins));
	ready_responder mem (.clk_sys(clk_sys), .nrst(nrst), .cycle_t1(t1), .cycle_t2(t2),
		.style(strap), .decoy(decoy), .delay(delay), .ready_in(rdy), .size_ack_pair(ack));
	always #5 clk_sys = ~clk_sys;
	task complete_run;
		$display("Checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= dma_cycle_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// Counts T2 clocks of one DMA cycle under the given mode and partner pace
	task run(input logic sync, input logic [1:0] wc, input logic [3:0] dl, input logic dc);
		int n;
		ahb(1'b1, dma_cycle_pkg::CFG_OFFSET, {21'h0, sync, 2'h0, wc, 6'h0});
		delay <= dl;
		decoy <= dc;
		dma_req <= 1'b1;
		@(posedge clk_sys);
		dma_req <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge clk_sys);
			if (done === 1'b1) break;
			n += int'(t2);
		end
		check(32'(done), 32'h1);
		check(32'(n >= 1 + wc), 32'h1);
		check(32'(sync || n >= 2), 32'h1);
		check(32'(n >= dl), 32'h1);
		check(32'(n <= 3 + wc + dl), 32'h1);
		ahb(1'b0, dma_cycle_pkg::STATUS_OFFSET, 32'h0);
		check(32'(rd[15:8]), 32'(n + 1));
		check(32'(rd[1:0]), {30'h0, sync, 1'b0});
	endtask : run
	initial begin
		clk_sys = 0; nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
		dma_req = 0; strap = 0; decoy = 1; delay = 0; pins = 2'h2;
		miscompares = 0; checks_done = 0;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ahb(1'b0, dma_cycle_pkg::CFG_OFFSET, 32'h0);
		check(32'(rd[9:8]), 32'h2);
		pins <= 2'h1;
		ahb(1'b1, dma_cycle_pkg::CFG_OFFSET, 32'h300);
		ahb(1'b0, dma_cycle_pkg::CFG_OFFSET, 32'h0);
		check(32'(rd[9:8]), 32'h2);
		for (int s = 0; s < 2; s++)
			for (int w = 0; w < 4; w++) run(s[0], w[1:0], 4'h0, 1'b1);
		run(1'b0, 2'h1, 4'h6, 1'b0);
		run(1'b1, 2'h0, 4'h6, 1'b0);
		// Straps settle before and after release, as the capture path needs
		nrst <= 1'b0;
		strap <= 1'b1;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ahb(1'b0, dma_cycle_pkg::STATUS_OFFSET, 32'h0);
		check(32'(rd[2]), 32'h1);
		ahb(1'b0, dma_cycle_pkg::CFG_OFFSET, 32'h0);
		check(32'(rd[9:8]), 32'h1);
		run(1'b0, 2'h0, 4'h5, 1'b1);
		run(1'b1, 2'h2, 4'h5, 1'b1);
		complete_run;
	end
	initial begin
		#50000;
		miscompares++;
		$display("Error at %0t: timeout", $time);
		complete_run;
	end
endmodule : tb
bind dma_bus_cycle_config dma_cycle_checker chk (.clk_sys(clk_sys), .nrst(nrst),
	.hreadyout(hreadyout), .hresp(hresp), .cycle_t1(cycle_t1), .cycle_t2(cycle_t2),
	.cycle_done(cycle_done), .ready_in(ready_in), .size_ack_pair(size_ack_pair));
